//--- hw/shreg_params.svh
`ifndef SHREG_PARAMS_SVH
`define SHREG_PARAMS_SVH

// ----------------------------------------------------------------------
// Segment and chain geometry
// ----------------------------------------------------------------------
`define SH_SEG_LEN 16
`define SH_TAP_W 4
`define SH_SEG_INIT 16'h0000
`define SH_CHAIN_LEN 40
`define SH_LFSR_SEGS 3
`define SH_LFSR_EXT 4
`define SH_LFSR_TAP_A 49
`define SH_LFSR_TAP_B 52
`define SH_SEQ_W 4
`define SH_WIDE_W 8
`define SH_WIDE_D 16
`define SH_WIDE_MAX_W 256
`define SH_WIDE_MAX_D 1024

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SH_ADDR_W 12
`define SH_OFS_CTRL 12'h000
`define SH_OFS_TAP 12'h004
`define SH_OFS_WTAP 12'h008
`define SH_OFS_STEP 12'h00C
`define SH_OFS_STATUS 12'h010

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define SH_CTRL_W 14
`define SH_CTRL_MODE 0
`define SH_CTRL_DYN 2
`define SH_CTRL_ALT39 3
`define SH_CTRL_XNOR 4
`define SH_CTRL_RUN 5
`define SH_CTRL_WVAR 6
`define SH_CTRL_WCE 7
`define SH_CTRL_SSET 8
`define SH_CTRL_SCLR 9
`define SH_CTRL_SINIT 10
`define SH_CTRL_ASET 11
`define SH_CTRL_ACLR 12
`define SH_CTRL_AINIT 13
`define SH_CTRL_RST 14'h0010
`define SH_TAP_REG_W 6
`define SH_TAP_RST 6'h00
`define SH_WTAP_W 10
`define SH_WTAP_RST 10'h000
`define SH_STAT_SEQ 4

`endif

//--- hw/shreg_pkg.sv
package shreg_pkg;
    // Operating modes of the main chain area
    typedef enum logic [1:0] {
        MODE_DELAY = 2'b00,
        MODE_LFSR = 2'b01,
        MODE_SEQ = 2'b10
    } chain_mode_t;
endpackage

//--- hw/seg_if.sv
`timescale 1ns/1ps
`default_nettype none
// Signals between a user and one cascadable 16-bit segment
interface seg_if;
    logic ce;
    logic din;
    logic [3:0] tap_sel;
    logic tap_out;
    logic chain_last_bit_out;
    modport seg (input ce, din, tap_sel, output tap_out, chain_last_bit_out);
    modport user (output ce, din, tap_sel, input tap_out, chain_last_bit_out);
endinterface
`default_nettype wire

//--- hw/cascadable_lut_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "shreg_params.svh"
module cascadable_lut_shifter #(
    parameter logic [`SH_SEG_LEN-1:0] INIT = `SH_SEG_INIT
) (
    input wire logic mclk,
    seg_if.seg port
);
    import shreg_pkg::*;

    // Storage, preloaded at configuration, never reset
    logic [`SH_SEG_LEN-1:0] store_q = INIT;

    // Enabled shift: din into stage 0, all others move up
    always_ff @(posedge mclk)
    begin
        if (port.ce)
        begin
            store_q <= {store_q[`SH_SEG_LEN-2:0], port.din};
        end
    end

    // Tap read is combinational; cascade is always the top stage
    assign port.tap_out = store_q[port.tap_sel];
    assign port.chain_last_bit_out = store_q[`SH_SEG_LEN-1];
endmodule
`default_nettype wire

//--- hw/wide_delay_line.sv
`timescale 1ns/1ps
`default_nettype none
`include "shreg_params.svh"
module wide_delay_line #(
    parameter int WIDTH = `SH_WIDE_W,
    parameter int DEPTH = `SH_WIDE_D,
    parameter logic [WIDTH-1:0] OUT_INIT = '0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    input wire logic var_len,
    input wire logic [$clog2(DEPTH)-1:0] tap,
    input wire logic out_ce_en,
    input wire logic out_ce,
    input wire logic sset,
    input wire logic sclr,
    input wire logic sinit,
    input wire logic aset,
    input wire logic aclr,
    input wire logic ainit,
    output logic [WIDTH-1:0] dout_q
);
    import shreg_pkg::*;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] sel;
    logic async_any;

    // Whole words shift together, no reset on storage
    always_ff @(posedge mclk)
    begin
        if (ce)
        begin
            mem_q[0] <= din;
            for (int i = 1; i < DEPTH; i++)
            begin
                mem_q[i] <= mem_q[i-1];
            end
        end
    end

    // Fixed length uses the last stage, variable uses the run-time tap
    assign sel = var_len ? mem_q[tap] : mem_q[DEPTH-1];
    assign async_any = aset | aclr | ainit;

    // Output register with selectable async and sync controls
    always_ff @(posedge mclk or posedge async_any)
    begin
        if (async_any)
        begin
            dout_q <= aclr ? '0 : (aset ? '1 : OUT_INIT);
        end
        else if (rst)
        begin
            dout_q <= OUT_INIT;
        end
        else if (!out_ce_en || out_ce)
        begin
            // Sync priority: clear, then set, then init
            dout_q <= sclr ? '0 : (sset ? '1 : (sinit ? OUT_INIT : sel));
        end
    end
endmodule
`default_nettype wire

//--- hw/shreg_chain_top.sv
// What this block does
// - The selected tap feeds an output flip-flop, never a port directly.
// - That output flip-flop runs on the same clock as the storage.
// - With the output flop as last stage, tap points one below the plain length only when ALT39 is set; static tap 0111 gives 40 plus the flop.
// - The chain's last bit is also captured in its own flip-flop.
// - Static 40-bit chain: full segments cascaded, final tap fixed at 0111.
// - Alternative: 39-bit chain with final tap 0110 plus one flop.
// - A segment's delay at its tap equals tap select plus one.
// - Wide variant shifts words of up to 256 bits, up to 1024 deep.
// - Wide variant is fixed-length or run-time variable-length.
// - Wide output register offers enable, async and sync set, clear, init.
// - LFSR mode feeds XOR or XNOR of taps back to the serial input.
// - The 52-bit LFSR takes feedback from bits 49 and 52.
// - Sequence counter: each bit a circulating 16-stage segment, any pattern.
// - Sequence counter gives a terminal count from a carry-style chain.
// - Each segment preloads a configurable pattern, zero by default.
// - Enabled edge loads serial input at stage 0 and moves bits up.
// - Four-bit tap select reads stages 0 to 15 combinationally.
// - Cascade output is stage 15, changing only after an enabled shift.
// - Reset leaves shift storage untouched; no set, reset or load.
`timescale 1ns/1ps
`default_nettype none
`include "shreg_params.svh"
module shreg_chain_top #(
    parameter int CHAIN_LEN = `SH_CHAIN_LEN,
    parameter int SEQ_W = `SH_SEQ_W,
    parameter int WIDE_W = `SH_WIDE_W,
    parameter int WIDE_D = `SH_WIDE_D
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SH_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in,
    input wire logic shift_ce_in,
    input wire logic [WIDE_W-1:0] wide_din,
    input wire logic wide_ce_in,
    output logic chain_q,
    output logic chain_last_q,
    output logic lfsr_q,
    output logic [SEQ_W-1:0] seq_q,
    output logic seq_tc,
    output logic [WIDE_W-1:0] wide_q
);
    import shreg_pkg::*;

    // ------------------------------------------------------------------
    // Derived geometry
    // ------------------------------------------------------------------
    localparam int NSEG = (CHAIN_LEN + `SH_SEG_LEN - 1) / `SH_SEG_LEN;
    localparam int SEGW = (NSEG > 1) ? $clog2(NSEG) : 1;
    localparam logic [3:0] FIN_TAP = 4'((CHAIN_LEN - 1) % `SH_SEG_LEN);
    localparam logic [3:0] FIN_TAP_ALT = 4'((CHAIN_LEN - 2) % `SH_SEG_LEN);
    localparam int WTW = $clog2(WIDE_D);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [`SH_CTRL_W-1:0] ctrl_q;
    logic [`SH_TAP_REG_W-1:0] tap_q;
    logic [`SH_WTAP_W-1:0] wtap_q;
    logic step_q;
    logic step_bit_q;
    logic [SEQ_W-1:0] seq_load_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic access;
    logic commit;
    logic hit;
    logic [31:0] rd_d;
    chain_mode_t mode;

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
    assign mode = chain_mode_t'(ctrl_q[`SH_CTRL_MODE +: 2]);

    // ------------------------------------------------------------------
    // APB slave: one wait state, answer registered
    // ------------------------------------------------------------------
    // First access cycle computes the answer, second completes it
    assign access = psel & penable & ~pready_q;
    assign commit = psel & penable & pready_q;

    // Address decode and read mux
    always_comb
    begin
        hit = 1'b1;
        rd_d = 32'h0000_0000;
        unique case (paddr)
            `SH_OFS_CTRL: rd_d[`SH_CTRL_W-1:0] = ctrl_q;
            `SH_OFS_TAP: rd_d[`SH_TAP_REG_W-1:0] = tap_q;
            `SH_OFS_WTAP: rd_d[`SH_WTAP_W-1:0] = wtap_q;
            `SH_OFS_STEP: rd_d = 32'h0000_0000;
            `SH_OFS_STATUS:
            begin
                rd_d[0] = chain_q;
                rd_d[1] = chain_last_q;
                rd_d[2] = lfsr_q;
                rd_d[3] = seq_tc;
                rd_d[`SH_STAT_SEQ +: SEQ_W] = seq_q;
            end
            default: hit = 1'b0;
        endcase
    end

    // Handshake flops
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= access;
            pslverr_q <= access & ~hit;
            prdata_q <= (access && !pwrite) ? rd_d : 32'h0000_0000;
        end
    end

    // Writable registers, updated at the completing edge only
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_q <= `SH_CTRL_RST;
            tap_q <= `SH_TAP_RST;
            wtap_q <= `SH_WTAP_RST;
        end
        else if (commit && pwrite)
        begin
            if (paddr == `SH_OFS_CTRL)
            begin
                ctrl_q <= pwdata[`SH_CTRL_W-1:0];
            end
            if (paddr == `SH_OFS_TAP)
            begin
                tap_q <= pwdata[`SH_TAP_REG_W-1:0];
            end
            if (paddr == `SH_OFS_WTAP)
            begin
                wtap_q <= pwdata[`SH_WTAP_W-1:0];
            end
        end
    end

    // Step write: one shift pulse carrying its data bits
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            step_q <= 1'b0;
            step_bit_q <= 1'b0;
            seq_load_q <= '0;
        end
        else
        begin
            step_q <= commit & pwrite & (paddr == `SH_OFS_STEP);
            if (commit && pwrite && paddr == `SH_OFS_STEP)
            begin
                step_bit_q <= pwdata[0];
                seq_load_q <= pwdata[1 +: SEQ_W];
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared shift enable
    // ------------------------------------------------------------------
    logic chain_ce;
    logic chain_din;

    // Software step or user logic enable, same clock domain
    assign chain_ce = step_q | (ctrl_q[`SH_CTRL_RUN] & shift_ce_in);
    assign chain_din = step_q ? step_bit_q : serial_in;

    // ------------------------------------------------------------------
    // Main delay chain
    // ------------------------------------------------------------------
    seg_if chain_if[NSEG] ();
    logic [NSEG-1:0] seg_tap;
    logic [SEGW-1:0] seg_idx;
    logic tap_sel_out;

    generate
        for (genvar g = 0; g < NSEG; g++)
        begin : g_chain
            cascadable_lut_shifter #(.INIT(`SH_SEG_INIT)) u_seg (
                .mclk(mclk),
                .port(chain_if[g])
            );
            assign chain_if[g].ce = chain_ce;
            assign seg_tap[g] = chain_if[g].tap_out;
            // Cascade through last-bit outputs, no extra muxes
            if (g == 0)
            begin : g_first
                assign chain_if[g].din = chain_din;
            end
            else
            begin : g_next
                assign chain_if[g].din = chain_if[g-1].chain_last_bit_out;
            end
            // Only the final segment uses a fixed tap in static mode
            if (g == NSEG - 1)
            begin : g_final
                assign chain_if[g].tap_sel = ctrl_q[`SH_CTRL_DYN] ? tap_q[3:0]
                    : (ctrl_q[`SH_CTRL_ALT39] ? FIN_TAP_ALT : FIN_TAP);
            end
            else
            begin : g_mid
                assign chain_if[g].tap_sel = tap_q[3:0];
            end
        end
    endgenerate

    // Dynamic tap picks a segment by the upper tap bits
    assign seg_idx = ctrl_q[`SH_CTRL_DYN] ? SEGW'(tap_q[`SH_TAP_REG_W-1:`SH_TAP_W])
        : SEGW'(NSEG - 1);
    assign tap_sel_out = seg_tap[seg_idx];

    // Output flop is one further stage on the chain clock
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            chain_q <= 1'b0;
            chain_last_q <= 1'b0;
        end
        else
        begin
            chain_q <= tap_sel_out;
            chain_last_q <= chain_if[NSEG-1].chain_last_bit_out;
        end
    end

    // ------------------------------------------------------------------
    // 52-bit LFSR: three segments plus four extension flops
    // ------------------------------------------------------------------
    seg_if lfsr_if[`SH_LFSR_SEGS] ();
    logic [`SH_LFSR_EXT-1:0] lfsr_ext_q = '0;
    logic lfsr_ce;
    logic lfsr_fb;
    logic lfsr_bit_a;
    logic lfsr_bit_b;

    assign lfsr_ce = chain_ce & (mode == MODE_LFSR);
    // Extension flops expose bits 49 to 52
    assign lfsr_bit_a = lfsr_ext_q[`SH_LFSR_TAP_A - `SH_LFSR_SEGS * `SH_SEG_LEN - 1];
    assign lfsr_bit_b = lfsr_ext_q[`SH_LFSR_TAP_B - `SH_LFSR_SEGS * `SH_SEG_LEN - 1];
    // XNOR avoids lock-up from the all-zero preload
    assign lfsr_fb = ctrl_q[`SH_CTRL_XNOR] ? ~(lfsr_bit_a ^ lfsr_bit_b)
        : (lfsr_bit_a ^ lfsr_bit_b);

    generate
        for (genvar l = 0; l < `SH_LFSR_SEGS; l++)
        begin : g_lfsr
            cascadable_lut_shifter #(.INIT(`SH_SEG_INIT)) u_seg (
                .mclk(mclk),
                .port(lfsr_if[l])
            );
            assign lfsr_if[l].ce = lfsr_ce;
            assign lfsr_if[l].tap_sel = 4'h0;
            if (l == 0)
            begin : g_first
                assign lfsr_if[l].din = lfsr_fb;
            end
            else
            begin : g_next
                assign lfsr_if[l].din = lfsr_if[l-1].chain_last_bit_out;
            end
        end
    endgenerate

    // Extension flops continue the chain, no reset
    always_ff @(posedge mclk)
    begin
        if (lfsr_ce)
        begin
            lfsr_ext_q <= {lfsr_ext_q[`SH_LFSR_EXT-2:0],
                lfsr_if[`SH_LFSR_SEGS-1].chain_last_bit_out};
        end
    end

    // Registered LFSR output
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            lfsr_q <= 1'b0;
        end
        else
        begin
            lfsr_q <= lfsr_bit_b;
        end
    end

    // ------------------------------------------------------------------
    // Sequence counter: one circulating segment per output bit
    // ------------------------------------------------------------------
    seg_if seq_if[SEQ_W] ();
    logic seq_ce;
    logic [SEQ_W:0] carry;
    logic [SEQ_W-1:0] seq_last;

    // Circulate in counter mode, otherwise load from step writes
    assign seq_ce = (mode == MODE_SEQ) ? chain_ce : step_q;
    assign carry[0] = 1'b1;

    generate
        for (genvar s = 0; s < SEQ_W; s++)
        begin : g_seq
            cascadable_lut_shifter #(.INIT(`SH_SEG_INIT)) u_seg (
                .mclk(mclk),
                .port(seq_if[s])
            );
            assign seq_if[s].ce = seq_ce;
            assign seq_if[s].tap_sel = 4'h0;
            assign seq_if[s].din = (mode == MODE_SEQ) ? seq_if[s].chain_last_bit_out
                : seq_load_q[s];
            assign seq_last[s] = seq_if[s].chain_last_bit_out;
            // Ripple carry combining of state bits
            assign carry[s+1] = carry[s] & seq_last[s];
        end
    endgenerate

    // Registered state and terminal count
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            seq_tc <= 1'b0;
            seq_q <= '0;
        end
        else
        begin
            seq_tc <= carry[SEQ_W];
            seq_q <= seq_last;
        end
    end

    // ------------------------------------------------------------------
    // Wide generated delay line
    // ------------------------------------------------------------------
    wide_delay_line #(
        .WIDTH(WIDE_W),
        .DEPTH(WIDE_D),
        .OUT_INIT('0)
    ) u_wide (
        .mclk(mclk),
        .rst(rst),
        .ce(wide_ce_in),
        .din(wide_din),
        .var_len(ctrl_q[`SH_CTRL_WVAR]),
        .tap(wtap_q[WTW-1:0]),
        .out_ce_en(ctrl_q[`SH_CTRL_WCE]),
        .out_ce(wide_ce_in),
        .sset(ctrl_q[`SH_CTRL_SSET]),
        .sclr(ctrl_q[`SH_CTRL_SCLR]),
        .sinit(ctrl_q[`SH_CTRL_SINIT]),
        .aset(ctrl_q[`SH_CTRL_ASET]),
        .aclr(ctrl_q[`SH_CTRL_ACLR]),
        .ainit(ctrl_q[`SH_CTRL_AINIT]),
        .dout_q(wide_q)
    );
endmodule
`default_nettype wire

//--- verif/user_logic_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Same-clock user logic that feeds the chain as a delay line
// ----------------------------------------------------------------------
module user_logic_model (
    input wire logic mclk,
    input wire logic en,
    output logic serial_in,
    output logic shift_ce_in,
    output logic [63:0] hist_q
);
    logic [6:0] pat_q = 7'h01;

    // Pattern of period 127, so no two chain depths look alike
    always @(posedge mclk)
        pat_q <= {pat_q[5:0], pat_q[6] ^ pat_q[5]};

    // Record of every bit handed over on an enabled shift
    always @(posedge mclk)
        if (shift_ce_in)
            hist_q <= {hist_q[62:0], serial_in};

    assign serial_in = pat_q[0];
    assign shift_ce_in = en;
endmodule
`default_nettype wire

//--- verif/shreg_chain_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "shreg_params.svh"
module shreg_chain_asserts #(
    parameter int SEQ_W = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SH_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_in,
    input wire logic shift_ce_in,
    input wire logic chain_q,
    input wire logic chain_last_q,
    input wire logic lfsr_q,
    input wire logic [SEQ_W-1:0] seq_q,
    input wire logic seq_tc
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [`SH_CTRL_W-1:0] ctrl_q;
    logic [7:0] run_q;
    logic plain;

    // Shadow of the control word
    always_ff @(posedge mclk)
    begin
        if (rst)
            ctrl_q <= `SH_CTRL_RST;
        else if (psel && penable && pready && pwrite && paddr == `SH_OFS_CTRL)
            ctrl_q <= pwdata[`SH_CTRL_W-1:0];
    end

    // Cycles of unbroken enabled shifting since the last access
    always_ff @(posedge mclk)
    begin
        if (rst || pready || !shift_ce_in || !ctrl_q[`SH_CTRL_RUN])
            run_q <= 8'h00;
        else if (run_q != 8'hFF)
            run_q <= run_q + 8'h01;
    end

    // Chain full in delay mode
    assign plain = run_q > 8'h3C && ctrl_q[1:0] == 2'b00;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero while idle");
    a_tc_ones: assert property (seq_tc |-> (&seq_q || &$past(seq_q)))
        else $error("terminal count without full state");
    a_hold_still: assert property ((!shift_ce_in && !psel && !pready)[*6]
        |-> $stable(chain_q) && $stable(chain_last_q) && $stable(lfsr_q) && $stable(seq_q))
        else $error("storage moved without shift");
    a_static_forty: assert property (plain && !ctrl_q[2] && !ctrl_q[3]
        |-> chain_q == $past(serial_in, 41))
        else $error("static chain delay wrong");
    a_alt_forty: assert property (plain && !ctrl_q[2] && ctrl_q[3]
        |-> chain_q == $past(serial_in, 40))
        else $error("short chain delay wrong");
    a_last_reg: assert property (plain |-> chain_last_q == $past(serial_in, 49))
        else $error("registered last bit wrong");

    c_static: cover property (plain && !ctrl_q[2] && !ctrl_q[3]);
    c_alt: cover property (plain && ctrl_q[3]);
    c_tc: cover property (seq_tc);
    c_err: cover property (pslverr);
endmodule

bind shreg_chain_top shreg_chain_asserts #(.SEQ_W(SEQ_W)) shreg_chain_asserts_i (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serial_in, .shift_ce_in, .chain_q, .chain_last_q, .lfsr_q,
    .seq_q, .seq_tc
);
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "shreg_params.svh"
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`SH_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [7:0] wide_din = 8'hA5;
    logic wide_ce_in = 1'b1;
    logic en = 1'b0;
    logic hung = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, serial_in, shift_ce_in;
    logic chain_q, chain_last_q, lfsr_q, seq_tc;
    logic [3:0] seq_q;
    logic [7:0] wide_q;
    logic [63:0] hist_q;
    int err_total = 0;
    int checked = 0;

    shreg_chain_top shreg_chain_top_i (
        .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .serial_in, .shift_ce_in, .wide_din, .wide_ce_in,
        .chain_q, .chain_last_q, .lfsr_q, .seq_q, .seq_tc, .wide_q
    );
    user_logic_model user_logic_model_i (.mclk, .en, .serial_in, .shift_ce_in, .hist_q);

    // 10 MHz clock
    initial
    begin
        forever #50 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [`SH_ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
            hung = 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [`SH_ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rd, e);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rchk("ctrl", `SH_OFS_CTRL, 32'h0000_0010);
        rchk("tap", `SH_OFS_TAP, 32'h0000_0000);
        rchk("wtap", `SH_OFS_WTAP, 32'h0000_0000);
        apb(1'b1, `SH_OFS_WTAP, 32'hFFFF_FFFF);
        rchk("wtap mask", `SH_OFS_WTAP, 32'h0000_03FF);
        apb(1'b1, `SH_OFS_STATUS, 32'hFFFF_FFFF);
        check("status write err", err, 1'b0);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check("unmapped err", err, 1'b1);
    endtask

    task automatic t_hold();
        apb(1'b1, `SH_OFS_CTRL, 32'h0000_0004);
        apb(1'b1, `SH_OFS_STEP, 32'h0000_0001);
        repeat (3) @(negedge mclk);
        check("step tap0", chain_q, 1'b1);
        rchk("status", `SH_OFS_STATUS, 32'h0000_0001);
        apb(1'b1, `SH_OFS_STEP, 32'h0000_0000);
        repeat (3) @(negedge mclk);
        check("step moved", chain_q, 1'b0);
        apb(1'b1, `SH_OFS_TAP, 32'h0000_0001);
        @(negedge mclk); // New tap shows one clock later
        repeat (10)
        begin
            @(negedge mclk);
            check("tap1 idle", chain_q, 1'b1);
        end
        @(posedge mclk);
        en <= 1'b1;
        repeat (10)
        begin
            @(negedge mclk);
            check("tap1 run off", chain_q, 1'b1);
        end
    endtask

    task automatic t_delay(input logic [31:0] c, input logic [31:0] t, input int idx);
        apb(1'b1, `SH_OFS_TAP, t);
        apb(1'b1, `SH_OFS_CTRL, c);
        en <= 1'b1;
        repeat (70) @(negedge mclk);
        repeat (16)
        begin
            @(negedge mclk);
            check("chain_q", chain_q, hist_q[idx]);
            check("chain_last_q", chain_last_q, hist_q[48]);
        end
    endtask

    task automatic t_lfsr();
        logic [52:1] m;
        m = '0;
        for (int x = 1; x >= 0; x--)
        begin
            apb(1'b1, `SH_OFS_CTRL, x ? 32'h0000_0011 : 32'h0000_0001);
            repeat (70)
            begin
                apb(1'b1, `SH_OFS_STEP, 32'h0000_0000);
                m = {m[51:1], m[49] ^ m[52] ^ x[0]};
                repeat (3) @(negedge mclk);
                check("lfsr_q", lfsr_q, m[52]);
            end
        end
    endtask

    task automatic t_seq();
        apb(1'b1, `SH_OFS_CTRL, 32'h0000_0000);
        for (int i = 0; i < 16; i++)
            apb(1'b1, `SH_OFS_STEP, i << 1);
        apb(1'b1, `SH_OFS_CTRL, 32'h0000_0002);
        for (int i = 1; i <= 17; i++)
        begin
            apb(1'b1, `SH_OFS_STEP, 32'h0000_0000);
            repeat (3) @(negedge mclk);
            check("seq_q", seq_q, i[3:0]);
            check("seq_tc", seq_tc, i[3:0] == 4'hF);
        end
    endtask

    task automatic t_wide(input logic [31:0] c, input logic [7:0] e);
        apb(1'b1, `SH_OFS_CTRL, c);
        repeat (40) @(negedge mclk);
        check("wide_q", wide_q, e);
    endtask

    // Cuts a hang short
    initial
    begin
        fork
            wait (hung);
            repeat (60000) @(posedge mclk);
        join_any
        err_total++;
        test_done();
    end

    // Main sequence
    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_hold();
        t_delay(32'h0000_0020, 32'h0000_0000, 40);
        t_delay(32'h0000_0028, 32'h0000_0000, 39);
        t_delay(32'h0000_0024, 32'h0000_0000, 1);
        t_delay(32'h0000_0024, 32'h0000_000F, 16);
        t_delay(32'h0000_0024, 32'h0000_0010, 17);
        t_delay(32'h0000_0024, 32'h0000_0027, 40);
        en <= 1'b0;
        t_lfsr();
        t_seq();
        t_wide(32'h0000_0000, 8'hA5);
        apb(1'b1, `SH_OFS_WTAP, 32'h0000_0003);
        t_wide(32'h0000_00C0, 8'hA5);
        @(posedge mclk);
        wide_din <= 8'h3C;
        repeat (6) @(negedge mclk);
        check("wide tap", wide_q, 8'h3C);
        t_wide(32'h0000_0100, 8'hFF);
        t_wide(32'h0000_0300, 8'h00);
        t_wide(32'h0000_0800, 8'hFF);
        t_wide(32'h0000_1800, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
